// ### rtl/lpr_pkg.sv
// Package: register map, field layout, reset values and timing for the readout core
package lpr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_NEAR_CFG      = 8'h01;
    localparam logic [7:0] ADDR_LIGHT_CFG     = 8'h02;
    localparam logic [7:0] ADDR_LIGHT_IRCORR  = 8'h03;
    localparam logic [7:0] ADDR_INT_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_NEAR_LOW_THR  = 8'h05;
    localparam logic [7:0] ADDR_NEAR_HIGH_THR = 8'h06;
    localparam logic [7:0] ADDR_LIGHT_LOW_UP  = 8'h07;
    localparam logic [7:0] ADDR_LIGHT_NIBBLES = 8'h08;
    localparam logic [7:0] ADDR_LIGHT_HIGH_LO = 8'h09;
    localparam logic [7:0] ADDR_NEAR_RESULT   = 8'h0A;
    localparam logic [7:0] ADDR_LIGHT_RES_HI  = 8'h0B;
    localparam logic [7:0] ADDR_LIGHT_RES_LO  = 8'h0C;
    localparam logic [7:0] ADDR_AMBIENT       = 8'h0D;
    localparam logic [7:0] ADDR_SOFT_RESET    = 8'h0E;
    // Reset values
    localparam logic [7:0] RST_NEAR_CFG       = 8'h00;
    localparam logic [7:0] RST_LIGHT_CFG      = 8'h00;
    localparam logic [7:0] RST_LIGHT_IRCORR   = 8'h00;
    localparam logic [7:0] RST_INT_STATUS     = 8'h10;
    localparam logic [7:0] RST_NEAR_LOW_THR   = 8'h00;
    localparam logic [7:0] RST_NEAR_HIGH_THR  = 8'hFF;
    localparam logic [7:0] RST_LIGHT_LOW_UP   = 8'h00;
    localparam logic [7:0] RST_LIGHT_NIBBLES  = 8'h0F;
    localparam logic [7:0] RST_LIGHT_HIGH_LO  = 8'hFF;
    localparam logic [7:0] SOFT_RESET_CODE    = 8'h38;
    localparam logic [7:0] SOFT_RESET_IDLE    = 8'h00;
    // Field positions
    localparam int NEAR_EN_BIT       = 5;
    localparam int NEAR_SLP_LSB      = 2;
    localparam int LIGHT_EN_BIT      = 2;
    localparam int NEAR_SCHEME_BIT   = 7;
    localparam int INT_NEAR_FLAG     = 7;
    localparam int INT_NEAR_PRST_LSB = 5;
    localparam int INT_BROWNOUT      = 4;
    localparam int INT_LIGHT_FLAG    = 3;
    localparam int INT_LIGHT_PRST_LSB= 1;
    localparam int INT_PIN_CFG       = 0;
    // Timing in microseconds (light) and nanoseconds (near) and derived cycle counts at 250 MHz
    localparam int CLK_MHZ           = 250;
    localparam int LIGHT_INTEG_US    = 200000;
    localparam int NEAR_CONV_NS      = 960000;
    localparam int NEAR_PULSE_NS     = 200000;
    localparam int LIGHT_INTEG_CYC   = LIGHT_INTEG_US * CLK_MHZ;
    localparam int NEAR_CONV_CYC     = NEAR_CONV_NS / 4;
    localparam int NEAR_PULSE_CYC    = NEAR_PULSE_NS / 4;
    localparam int SLEEP_UNIT_CYC    = 12500000;

    // Host register access bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Analogue front end results bundle
    typedef struct packed {
        logic        light_done;
        logic [11:0] light_raw;
        logic [11:0] light_ir;
        logic        near_sample;
        logic [7:0]  near_level;
        logic        washout;
    } afe_in_t;
endpackage

// ### rtl/light_proximity_readout_core.sv
// Measurement sequencing and result registers of the light/proximity sensor
// What this block does
// R1: Near thresholds at 05/06, reset 00/FF
// R2: Two 12-bit light thresholds from three registers
// R3: Latest near result readable at 0A
// R4: Light result high nibble 0B, low byte 0C
// R5: 0D holds ambient IR and washout bit
// R6: Writing 38 to 0E resets the device
// R7: Brown-out sets flag, never drives interrupt
// R8: Host clears brown-out by writing zero
// R9: Light converts continuously, 200ms, updates at end
// R10: Near result subtracts pre/post pulse readings
// R11: Near channel repeats after selected sleep time
// R12: Near conversion 0.96ms, emitter first 0.2ms
// R13: Emitter output released outside drive pulse
// R14: Emitter current from two-bit field
// R15: Light only when enabled; range select
// R16: Reflected IR digitised to eight bits
// R17: Scaled IR correction subtracted from light
// R18: Host tunes IR correction below ten percent
// R19: Host checks washout before trusting result
// R20: Persistence needs 1/2/4/8 consecutive events
// R21: Pin needs both or either event
// R22: Light flag outside window, sticky till cleared
// R23: Near hysteresis set above high, clear below low
// R24: Light result bytes update together
`timescale 1ns/1ps
`default_nettype none
module light_proximity_readout_core #(
    parameter int LIGHT_INTEG = lpr_pkg::LIGHT_INTEG_CYC, // Light integration cycles
    parameter int SLEEP_UNIT  = lpr_pkg::SLEEP_UNIT_CYC,  // Cycles per sleep code step
    parameter int NEAR_CONV   = lpr_pkg::NEAR_CONV_CYC,   // Near conversion cycles
    parameter int NEAR_PULSE  = lpr_pkg::NEAR_PULSE_CYC   // Emitter drive cycles
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Register access from the serial port
    input  wire lpr_pkg::reg_req_t req,
    output logic [7:0]            rdata,
    // Analogue front end
    input  wire lpr_pkg::afe_in_t afe,
    input  wire logic             brownout_det,
    output logic                  light_run,
    output logic [1:0]            light_range,
    output logic [1:0]            emitter_current_sel,
    output logic                  near_sample_pre,
    output logic                  near_sample_post,
    // Emitter pin, enable low while driving
    output logic                  emitter_drive_out,
    output logic                  emitter_drive_oe_n,
    // Interrupt pin, active low
    output logic                  int_n
);
    import lpr_pkg::*;

    // Configuration and threshold registers
    logic [7:0] near_cfg_q, near_cfg_d;
    logic [7:0] light_cfg_q, light_cfg_d;
    logic [7:0] ircorr_q, ircorr_d;
    logic [7:0] int_q, int_d;               // Flags and persistence settings
    logic [7:0] near_low_thr_q, near_low_thr_d;
    logic [7:0] near_high_thr_q, near_high_thr_d;
    logic [7:0] light_low_thr_upper_q, light_low_thr_upper_d;
    logic [7:0] light_nib_q, light_nib_d;
    logic [7:0] light_high_thr_lower_q, light_high_thr_lower_d;
    // Result registers
    logic [7:0]  near_result_q, near_result_d;
    logic [11:0] light_res_q, light_res_d;  // One word so both bytes move as one
    logic [6:0]  ambient_ir_component_q, ambient_ir_component_d;
    logic        saturation_status_q, saturation_status_d;
    // Persistence counters and pin qualifiers
    logic [3:0] light_cnt_q, light_cnt_d, near_cnt_q, near_cnt_d;
    logic       light_evt_q, light_evt_d, near_evt_q, near_evt_d;
    logic       soft_rst_q, soft_rst_d;     // One-cycle soft reset pulse

    // Sequencer state
    typedef enum logic [3:0] {
        NS_IDLE  = 4'b0001,
        NS_PULSE = 4'b0010,
        NS_CONV  = 4'b0100,
        NS_SLEEP = 4'b1000
    } near_state_t;
    near_state_t ns_q, ns_d;
    logic [31:0] near_tmr_q, near_tmr_d;
    logic [7:0]  near_pre_q, near_pre_d;    // Ambient reading before the pulse

    // Persistence code to required event count
    function automatic logic [3:0] prst_need(input logic [1:0] code);
        // R20: 1/2/4/8 events
        prst_need = 4'd1 << code;
    endfunction

    // Sleep code to wait cycles
    function automatic logic [31:0] sleep_cycles(input logic [2:0] code);
        sleep_cycles = 32'(SLEEP_UNIT) * 32'({29'd0, code} + 32'd1);
    endfunction

    // Combinational controls
    logic        wr_int, light_done, near_done;
    logic [11:0] light_lo_thr, light_hi_thr, light_corr, light_val;
    logic [7:0]  near_val;
    logic        light_out, near_hi, near_lo;

    always_comb begin
        // R2: assemble thresholds
        light_lo_thr = {light_low_thr_upper_q, light_nib_q[7:4]};
        light_hi_thr = {light_nib_q[3:0], light_high_thr_lower_q};
        // R17: scaled correction, clamped at zero
        // Full-width product; a 12-bit product would wrap before the shift
        light_corr = 12'(({12'd0, afe.light_ir} * {19'd0, ircorr_q[4:0]}) >> 5);
        light_val  = (afe.light_raw > light_corr) ? afe.light_raw - light_corr : 12'h000;
        // R10: post minus pre reading
        near_val   = (afe.near_level > near_pre_q) ? afe.near_level - near_pre_q : 8'h00;
        // R9: conversion completes only while enabled
        light_done = light_cfg_q[LIGHT_EN_BIT] && afe.light_done;
        near_done  = (ns_q == NS_CONV) && (near_tmr_q == 32'd1);
        light_out  = (light_val < light_lo_thr) || (light_val > light_hi_thr);
        near_hi    = near_val > near_high_thr_q;
        near_lo    = near_val < near_low_thr_q;
        wr_int     = req.wr && (req.addr == ADDR_INT_STATUS);
    end

    // Near channel sequencer
    always_comb begin
        ns_d       = ns_q;
        near_tmr_d = (near_tmr_q != 32'd0) ? near_tmr_q - 32'd1 : 32'd0;
        near_pre_d = near_pre_q;
        case (ns_q)
            NS_IDLE: begin
                if (near_cfg_q[NEAR_EN_BIT]) begin
                    // R10: capture ambient before pulse
                    near_pre_d = afe.near_level;
                    ns_d       = NS_PULSE;
                    near_tmr_d = 32'(NEAR_PULSE);
                end
            end
            NS_PULSE: begin
                // R12: drive for first 0.2ms
                if (near_tmr_q == 32'd1) begin
                    ns_d       = NS_CONV;
                    near_tmr_d = 32'(NEAR_CONV - NEAR_PULSE);
                end
            end
            NS_CONV: begin
                if (near_tmr_q == 32'd1) begin
                    // R11: wait selected interval
                    ns_d       = NS_SLEEP;
                    near_tmr_d = sleep_cycles(near_cfg_q[NEAR_SLP_LSB +: 3]);
                end
            end
            NS_SLEEP: begin
                if (near_tmr_q <= 32'd1) begin
                    ns_d = NS_IDLE;
                end
            end
            default: ns_d = NS_IDLE;
        endcase
        // Disabling parks the channel at once
        if (!near_cfg_q[NEAR_EN_BIT]) begin
            ns_d = NS_IDLE;
        end
    end

    // Register writes, results and flags
    always_comb begin
        near_cfg_d             = near_cfg_q;
        light_cfg_d            = light_cfg_q;
        ircorr_d               = ircorr_q;
        near_low_thr_d         = near_low_thr_q;
        near_high_thr_d        = near_high_thr_q;
        light_low_thr_upper_d  = light_low_thr_upper_q;
        light_nib_d            = light_nib_q;
        light_high_thr_lower_d = light_high_thr_lower_q;
        near_result_d          = near_result_q;
        light_res_d            = light_res_q;
        ambient_ir_component_d = ambient_ir_component_q;
        saturation_status_d    = saturation_status_q;
        int_d                  = int_q;
        light_cnt_d            = light_cnt_q;
        near_cnt_d             = near_cnt_q;
        light_evt_d            = light_evt_q;
        near_evt_d             = near_evt_q;
        soft_rst_d             = 1'b0;
        if (req.wr) begin
            case (req.addr)
                ADDR_NEAR_CFG:      near_cfg_d = req.wdata;
                ADDR_LIGHT_CFG:     light_cfg_d = req.wdata;
                ADDR_LIGHT_IRCORR:  ircorr_d = {3'd0, req.wdata[4:0]};
                // R1: near thresholds
                ADDR_NEAR_LOW_THR:  near_low_thr_d = req.wdata;
                ADDR_NEAR_HIGH_THR: near_high_thr_d = req.wdata;
                ADDR_LIGHT_LOW_UP:  light_low_thr_upper_d = req.wdata;
                ADDR_LIGHT_NIBBLES: light_nib_d = req.wdata;
                ADDR_LIGHT_HIGH_LO: light_high_thr_lower_d = req.wdata;
                // R6: soft reset command
                ADDR_SOFT_RESET:    soft_rst_d = (req.wdata == SOFT_RESET_CODE);
                default: ;
            endcase
        end
        if (wr_int) begin
            // Settings bits follow the write; flags only clear on a zero
            int_d[6:5] = req.wdata[6:5];
            int_d[2:0] = req.wdata[2:0];
            // R8: brown-out cleared by zero
            int_d[INT_BROWNOUT]   = int_q[INT_BROWNOUT] & req.wdata[INT_BROWNOUT];
            int_d[INT_LIGHT_FLAG] = int_q[INT_LIGHT_FLAG] & req.wdata[INT_LIGHT_FLAG];
            int_d[INT_NEAR_FLAG]  = int_q[INT_NEAR_FLAG] & req.wdata[INT_NEAR_FLAG];
        end
        // R7: brown-out sets flag, set wins
        if (brownout_det) begin
            int_d[INT_BROWNOUT] = 1'b1;
        end
        if (light_done) begin
            // R24: both bytes from one word
            light_res_d = light_val;
            // R22: out of window sets sticky flag
            if (light_out) begin
                int_d[INT_LIGHT_FLAG] = 1'b1;
                light_cnt_d = (light_cnt_q < 4'd8) ? light_cnt_q + 4'd1 : light_cnt_q;
            end else begin
                light_cnt_d = 4'd0;
            end
            // R20: persistence on light events
            light_evt_d = light_out &&
                ((light_cnt_q + 4'd1) >= prst_need(int_q[INT_LIGHT_PRST_LSB +: 2]));
        end
        if (near_done) begin
            // R3: latest near result
            near_result_d = near_val;
            // R5: ambient component and washout
            ambient_ir_component_d = near_pre_q[7:1];
            saturation_status_d    = afe.washout;
            if (light_cfg_q[NEAR_SCHEME_BIT]) begin
                // R23: hysteresis set and clear
                if (near_hi) begin
                    int_d[INT_NEAR_FLAG] = 1'b1;
                end else if (near_lo) begin
                    int_d[INT_NEAR_FLAG] = 1'b0;
                end
            end else if (near_hi || near_lo) begin
                int_d[INT_NEAR_FLAG] = 1'b1;
            end
            near_cnt_d = (near_hi || near_lo) ?
                ((near_cnt_q < 4'd8) ? near_cnt_q + 4'd1 : near_cnt_q) : 4'd0;
            near_evt_d = (near_hi || near_lo) &&
                ((near_cnt_q + 4'd1) >= prst_need(int_q[INT_NEAR_PRST_LSB +: 2]));
        end
        // Host clearing a flag also drops its pin event
        if (wr_int && !req.wdata[INT_LIGHT_FLAG] && !light_done) begin
            light_evt_d = 1'b0;
            light_cnt_d = 4'd0;
        end
        if (wr_int && !req.wdata[INT_NEAR_FLAG] && !near_done) begin
            near_evt_d = 1'b0;
            near_cnt_d = 4'd0;
        end
    end

    // State registers; soft reset returns configuration to defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst || soft_rst_q) begin
            near_cfg_q             <= RST_NEAR_CFG;
            light_cfg_q            <= RST_LIGHT_CFG;
            ircorr_q               <= RST_LIGHT_IRCORR;
            near_low_thr_q         <= RST_NEAR_LOW_THR;
            near_high_thr_q        <= RST_NEAR_HIGH_THR;
            light_low_thr_upper_q  <= RST_LIGHT_LOW_UP;
            light_nib_q            <= RST_LIGHT_NIBBLES;
            light_high_thr_lower_q <= RST_LIGHT_HIGH_LO;
            near_result_q          <= 8'h00;
            light_res_q            <= 12'h000;
            ambient_ir_component_q <= 7'h00;
            saturation_status_q    <= 1'b0;
            int_q                  <= RST_INT_STATUS;
            light_cnt_q            <= 4'd0;
            near_cnt_q             <= 4'd0;
            light_evt_q            <= 1'b0;
            near_evt_q             <= 1'b0;
            soft_rst_q             <= 1'b0;
            ns_q                   <= NS_IDLE;
            near_tmr_q             <= 32'd0;
            near_pre_q             <= 8'h00;
        end else begin
            near_cfg_q             <= near_cfg_d;
            light_cfg_q            <= light_cfg_d;
            ircorr_q               <= ircorr_d;
            near_low_thr_q         <= near_low_thr_d;
            near_high_thr_q        <= near_high_thr_d;
            light_low_thr_upper_q  <= light_low_thr_upper_d;
            light_nib_q            <= light_nib_d;
            light_high_thr_lower_q <= light_high_thr_lower_d;
            near_result_q          <= near_result_d;
            light_res_q            <= light_res_d;
            ambient_ir_component_q <= ambient_ir_component_d;
            saturation_status_q    <= saturation_status_d;
            int_q                  <= int_d;
            light_cnt_q            <= light_cnt_d;
            near_cnt_q             <= near_cnt_d;
            light_evt_q            <= light_evt_d;
            near_evt_q             <= near_evt_d;
            soft_rst_q             <= soft_rst_d;
            ns_q                   <= ns_d;
            near_tmr_q             <= near_tmr_d;
            near_pre_q             <= near_pre_d;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        case (req.addr)
            ADDR_NEAR_CFG:      rdata = near_cfg_q;
            ADDR_LIGHT_CFG:     rdata = light_cfg_q;
            ADDR_LIGHT_IRCORR:  rdata = ircorr_q;
            ADDR_INT_STATUS:    rdata = int_q;
            ADDR_NEAR_LOW_THR:  rdata = near_low_thr_q;
            ADDR_NEAR_HIGH_THR: rdata = near_high_thr_q;
            ADDR_LIGHT_LOW_UP:  rdata = light_low_thr_upper_q;
            ADDR_LIGHT_NIBBLES: rdata = light_nib_q;
            ADDR_LIGHT_HIGH_LO: rdata = light_high_thr_lower_q;
            ADDR_NEAR_RESULT:   rdata = near_result_q;
            // R4: upper nibble zero
            ADDR_LIGHT_RES_HI:  rdata = {4'h0, light_res_q[11:8]};
            ADDR_LIGHT_RES_LO:  rdata = light_res_q[7:0];
            ADDR_AMBIENT:       rdata = {ambient_ir_component_q, saturation_status_q};
            ADDR_SOFT_RESET:    rdata = SOFT_RESET_IDLE;
            default:            rdata = 8'h00;
        endcase
    end

    // Pin and front-end outputs
    always_comb begin
        // R13: released outside pulse
        emitter_drive_oe_n  = (ns_q != NS_PULSE);
        emitter_drive_out   = (ns_q == NS_PULSE);
        // R14: current select
        emitter_current_sel = near_cfg_q[1:0];
        // R16: eight-bit sample strobes
        near_sample_pre     = (ns_q == NS_IDLE) && near_cfg_q[NEAR_EN_BIT];
        near_sample_post    = near_done;
        light_run           = light_cfg_q[LIGHT_EN_BIT];
        light_range         = light_cfg_q[1:0];
        // R21: both or either; R7 brown-out never reaches the pin
        int_n = int_q[INT_PIN_CFG] ? !(light_evt_q && near_evt_q)
                                   : !(light_evt_q || near_evt_q);
    end
endmodule
`default_nettype wire

// ### sim/afe_model.sv
// Front end stand-in: light conversions on request, near levels per pulse
`timescale 1ns/1ps
`default_nettype none
module afe_model (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Sample strobes from the core
    input  wire logic             near_sample_pre,
    input  wire logic             near_sample_post,
    // Scene set by the bench
    input  wire logic             fire,
    input  wire logic [11:0]      raw,
    input  wire logic [11:0]      ir,
    input  wire logic [7:0]       refl,
    input  wire logic             wash,
    // Readings into the core
    output var lpr_pkg::afe_in_t  afe
);
    import lpr_pkg::*;
    logic [7:0] level_d;  // Next near level
    logic [7:0] level_q;  // Near level seen by the core
    always_comb begin
        level_d = level_q;
        if (near_sample_pre) begin
            level_d = refl;
        end else if (near_sample_post) begin
            level_d = 8'h00;
        end
    end
    // Level register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level_q <= 8'h00;
        end else begin
            level_q <= level_d;
        end
    end
    // Light words are only valid with the done pulse; inverted otherwise
    always_comb begin
        afe = '0;
        afe.light_done = fire;
        afe.light_raw = fire ? raw : ~raw;
        afe.light_ir = fire ? ir : ~ir;
        afe.near_level = level_q;
        afe.washout = wash;
    end
endmodule
`default_nettype wire

// ### sim/lpr_checker.sv
// Port-level assertions for the readout core
`timescale 1ns/1ps
`default_nettype none
module lpr_checker #(
    parameter int NEAR_CONV  = 24,
    parameter int NEAR_PULSE = 5
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // Register side
    input  wire lpr_pkg::reg_req_t req,
    input  wire logic [7:0]        rdata,
    // Front end and pins
    input  wire lpr_pkg::afe_in_t  afe,
    input  wire logic              brownout_det,
    input  wire logic              light_run,
    input  wire logic [1:0]        light_range,
    input  wire logic [1:0]        emitter_current_sel,
    input  wire logic              near_sample_pre,
    input  wire logic              near_sample_post,
    input  wire logic              emitter_drive_out,
    input  wire logic              emitter_drive_oe_n,
    input  wire logic              int_n
);
    import lpr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    int         lo_d;  // Next count of drive cycles
    int         lo_q;  // Cycles the emitter has been driven
    logic [7:0] wd_q;  // Write data of the previous cycle
    // Count drive cycles, cleared when released
    always_comb begin
        lo_d = emitter_drive_oe_n ? 0 : lo_q + 1;
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lo_q <= 0;
            wd_q <= 8'h00;
        end else begin
            lo_q <= lo_d;
            wd_q <= req.wdata;
        end
    end
    a_pulse_length: assert property ($rose(emitter_drive_oe_n) |-> lo_q == NEAR_PULSE)
        else $error("pulse length");
    a_conv_end: assert property ($rose(emitter_drive_oe_n) |-> ##[1:NEAR_CONV] near_sample_post)
        else $error("conversion late");
    a_light_cfg: assert property (req.wr && req.addr == ADDR_LIGHT_CFG |=>
        light_run == wd_q[LIGHT_EN_BIT] && light_range == wd_q[1:0]) else $error("light cfg");
    a_drive_cfg: assert property (req.wr && req.addr == ADDR_NEAR_CFG |=>
        emitter_current_sel == wd_q[1:0]) else $error("drive current");
    a_thr_readback: assert property ((req.wr && req.addr == ADDR_NEAR_LOW_THR) ##1
        (!req.wr && req.addr == ADDR_NEAR_LOW_THR) |-> rdata == wd_q) else $error("threshold");
    a_result_nibble: assert property (req.addr == ADDR_LIGHT_RES_HI |-> rdata[7:4] == 4'h0)
        else $error("high nibble");
    a_ircorr_reserved: assert property (req.addr == ADDR_LIGHT_IRCORR |-> rdata[7:5] == 3'h0)
        else $error("reserved bits");
    a_soft_read_zero: assert property (req.addr == ADDR_SOFT_RESET |-> rdata == 8'h00)
        else $error("soft reset read");
    a_brownout_flag: assert property (brownout_det ##1 req.addr == ADDR_INT_STATUS |->
        rdata[INT_BROWNOUT]) else $error("brownout flag");
    a_unmapped_zero: assert property (req.addr == 8'h00 || req.addr > 8'h0E |-> rdata == 8'h00)
        else $error("unmapped read");
    c_pulse: cover property ($fell(emitter_drive_oe_n));
    c_light: cover property (afe.light_done && light_run);
    c_brown: cover property (brownout_det && int_n);
endmodule
bind light_proximity_readout_core lpr_checker #(.NEAR_CONV(NEAR_CONV), .NEAR_PULSE(NEAR_PULSE))
    u_lpr_checker (.*);
`default_nettype wire

// ### sim/tb_light_proximity_readout_core.sv
// Self-checking bench for the readout core
`timescale 1ns/1ps
`default_nettype none
module tb_light_proximity_readout_core;
    import lpr_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, brownout_det = 1'b0, fire = 1'b0, wash = 1'b0;
    reg_req_t req = '0;
    afe_in_t afe;
    logic [11:0] raw = 12'h000, ir = 12'h000;
    logic [7:0] refl = 8'h00, rdata;
    logic [1:0] light_range, emitter_current_sel;
    logic light_run, near_sample_pre, near_sample_post, emitter_drive_out, emitter_drive_oe_n, int_n;
    int err_total = 0, total_checks = 0;
    // Free-running 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    light_proximity_readout_core #(.LIGHT_INTEG(100), .SLEEP_UNIT(4), .NEAR_CONV(24),
        .NEAR_PULSE(5)) u_light_proximity_readout_core (.*);
    afe_model u_afe_model (.ref_clk, .nrst, .near_sample_pre, .near_sample_post, .fire, .raw,
        .ir, .refl, .wash, .afe);
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Strobe dropped and a cycle left so writes never collide
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        tick(1);
        req.wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
        req.addr = a;
        #1;
        chk8(nm, exp, rdata);
        tick(1);
    endtask
    // Bounded wait: 0 for drive start, 1 for conversion end
    task automatic wait_ev(int k);
        for (int i = 0; i < 400; i++) begin
            if ((k == 0 && emitter_drive_oe_n === 1'b0) || (k == 1 && near_sample_post === 1'b1)) begin
                return;
            end
            tick(1);
        end
        $display("[FAIL] near event %0d expected 1 seen timeout", k);
        err_total++;
        finish_test();
    endtask
    task automatic pulse_light(logic [11:0] r);
        raw = r;
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(3);
    endtask
    task automatic t_reset_values();
        logic [7:0] a[9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0E, 8'h00, 8'h20};
        logic [7:0] e[9] = '{8'h10, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd(a[i], e[i], "reset value");
        end
        wr(8'h0A, 8'h77);
        rd(8'h0A, 8'h00, "near result");
    endtask
    task automatic t_thresholds();
        for (int i = 5; i < 10; i++) begin
            wr(8'(i), 8'(8'hA0 + i));
            rd(8'(i), 8'(8'hA0 + i), "threshold");
        end
        wr(8'h0E, 8'h38);
        tick(3);
        t_reset_values();
    endtask
    task automatic t_light();
        wr(8'h02, 8'h07);
        chk8("light run", 8'h01, 8'(light_run));
        chk8("light range", 8'h03, 8'(light_range));
        wr(8'h03, 8'hF0);
        rd(8'h03, 8'h10, "ir correction");
        ir = 12'h100;
        pulse_light(12'hABC);
        rd(8'h0B, 8'h0A, "light high");
        rd(8'h0C, 8'h3C, "light low");
        rd(8'h04, 8'h10, "inside window");
        wr(8'h08, 8'h09);
        wr(8'h09, 8'h00);
        pulse_light(12'hABC);
        rd(8'h04, 8'h18, "light flag");
        chk8("int pin", 8'h00, 8'(int_n));
        wr(8'h04, 8'h12);
        rd(8'h04, 8'h12, "flag cleared");
        pulse_light(12'hABC);
        chk8("one of two events", 8'h01, 8'(int_n));
        pulse_light(12'hABC);
        chk8("two of two events", 8'h00, 8'(int_n));
        wr(8'h04, 8'h10);
        wr(8'h02, 8'h00);
        pulse_light(12'h123);
        rd(8'h0C, 8'h3C, "light disabled");
    endtask
    task automatic t_near();
        int n;
        n = 0;
        refl = 8'h5A;
        wash = 1'b1;
        wr(8'h01, 8'h22);
        chk8("drive current", 8'h02, 8'(emitter_current_sel));
        wait_ev(0);
        while (emitter_drive_oe_n === 1'b0 && n < 50) begin
            n++;
            tick(1);
        end
        chk8("pulse cycles", 8'(n), 8'h05);
        wait_ev(1);
        wr(8'h01, 8'h00);
        rd(8'h0A, 8'h5A, "near result");
        rd(8'h0D, 8'h01, "washout status");
        tick(40);
        chk8("emitter released", 8'h01, 8'(emitter_drive_oe_n));
    endtask
    task automatic t_brownout();
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h00, "brownout cleared");
        brownout_det = 1'b1;
        tick(1);
        brownout_det = 1'b0;
        rd(8'h04, 8'h10, "brownout flag");
        chk8("no interrupt", 8'h01, 8'(int_n));
    endtask
    initial begin
        tick(8);
        nrst = 1'b1;
        tick(1);
        t_reset_values();
        t_thresholds();
        t_light();
        t_near();
        t_brownout();
        finish_test();
    end
endmodule
`default_nettype wire
